// ### include/caf_pkg.sv
// package for the can acceptance filter: register map, layout, reset values
package caf_pkg;
    localparam int          CAF_DATA_W      = 32;
    localparam int          CAF_ADDR_W      = 8;
    localparam int          CAF_BYTE_W      = 8;
    localparam int          CAF_NBYTES      = 4;
    // register byte addresses
    localparam logic [7:0]  CAF_OFF_CODE0   = 8'h00;
    localparam logic [7:0]  CAF_OFF_CODE1   = 8'h04;
    localparam logic [7:0]  CAF_OFF_CODE2   = 8'h08;
    localparam logic [7:0]  CAF_OFF_CODE3   = 8'h0C;
    localparam logic [7:0]  CAF_OFF_MASK0   = 8'h10;
    localparam logic [7:0]  CAF_OFF_MASK1   = 8'h14;
    localparam logic [7:0]  CAF_OFF_MASK2   = 8'h18;
    localparam logic [7:0]  CAF_OFF_MASK3   = 8'h1C;
    localparam logic [7:0]  CAF_OFF_STATUS  = 8'h20;
    localparam logic [7:0]  CAF_OFF_ACOUNT  = 8'h24;
    localparam logic [7:0]  CAF_OFF_RCOUNT  = 8'h28;
    // reset values: pass everything
    localparam logic [7:0]  CAF_CODE_RST    = 8'h00;
    localparam logic [7:0]  CAF_MASK_RST    = 8'hFF;
    // status register fields
    localparam int          CAF_ST_VALID    = 0;
    localparam int          CAF_ST_ACCEPT   = 1;
    localparam int          CAF_ST_EXT      = 2;
    // standard frame: care bits of byte1 (upper nibble only)
    localparam logic [7:0]  CAF_STD_B1_USE  = 8'hF0;
    // extended frame: care bits of byte3 (low two ignored)
    localparam logic [7:0]  CAF_EXT_B3_USE  = 8'hFC;
    localparam logic [7:0]  CAF_ALL_USE     = 8'hFF;
    localparam int          CAF_CNT_W       = 16;
endpackage

// ### include/caf_filt_if.sv
// interface between the register file and the filter compare core
`timescale 1ns/1ps
interface caf_filt_if;
    logic [31:0] code;      // code bytes 3..0 packed, byte0 in [31:24]
    logic [31:0] mask;      // mask bytes packed the same way
    logic [31:0] frame;     // frame bits packed in filter order
    logic        ext;       // frame is extended
    logic        match;     // compare result
    modport regs (output code, output mask, output frame, output ext, input match);
    modport core (input code, input mask, input frame, input ext, output match);
endinterface

// ### rtl/caf_match.sv
// combinational compare core of the acceptance filter
`timescale 1ns/1ps
module caf_match
    import caf_pkg::*;
(
    caf_filt_if.core f      // filter operands and result
);
    logic [31:0] use_bits;
    logic [31:0] diff;

    always_comb begin
        if (f.ext) begin
            use_bits = {CAF_ALL_USE, CAF_ALL_USE, CAF_ALL_USE, CAF_EXT_B3_USE};
        end else begin
            use_bits = {CAF_ALL_USE, CAF_STD_B1_USE, CAF_ALL_USE, CAF_ALL_USE};
        end
        diff = (f.frame ^ f.code) & ~f.mask & use_bits;
    end

    assign f.match = (diff == 32'h0000_0000);
endmodule

// ### rtl/caf_top.sv
// can receive acceptance filter with apb register access
//
// Overview of operation
// - four code and four mask byte registers form a four-byte filter
// - mask bit zero compares frame bit with code bit; one means don't care
// - frame passes only when every compared bit equals its code bit
// - standard: byte0 compares the upper eight identifier bits
// - standard: byte1 upper nibble compares lowest three id bits then rtr
// - standard: byte1 lower nibble is ignored
// - standard: byte2 checks first data byte, byte3 second data byte
// - extended: all bits but byte3 low two check id and rtr
`timescale 1ns/1ps
module caf_top
    import caf_pkg::*;
#(
    parameter int CNT_W = CAF_CNT_W
) (
    input  wire logic                  pclk,         // apb clock, 10 MHz
    input  wire logic                  presetn,      // async reset, active low
    input  wire logic                  psel,         // apb select
    input  wire logic                  penable,      // apb access phase
    input  wire logic                  pwrite,       // apb write
    input  wire logic [CAF_ADDR_W-1:0] paddr,        // apb byte address
    input  wire logic [CAF_DATA_W-1:0] pwdata,       // apb write data
    input  wire logic [3:0]            pstrb,        // apb byte strobes
    output logic      [CAF_DATA_W-1:0] prdata,       // apb read data
    output logic                       pready,       // apb ready
    output logic                       pslverr,      // apb error
    input  wire logic                  rx_valid,     // received frame strobe
    input  wire logic                  rx_ext,       // frame is extended
    input  wire logic [28:0]           rx_id,        // identifier, std in [10:0]
    input  wire logic                  rx_rtr,       // remote request bit
    input  wire logic [7:0]            rx_data0,     // first data byte
    input  wire logic [7:0]            rx_data1,     // second data byte
    output logic                       acc_valid,    // decision strobe
    output logic                       acc_pass      // frame accepted
);
    import caf_pkg::*;

    logic [7:0]       code_r [CAF_NBYTES];
    logic [7:0]       mask_r [CAF_NBYTES];
    logic [2:0]       status_r;
    logic [CNT_W-1:0] acount_r;
    logic [CNT_W-1:0] rcount_r;
    logic             wr_en;
    logic             rd_en;
    logic             addr_ok;
    logic [CAF_DATA_W-1:0] rd_nxt;
    logic             hit;

    caf_filt_if fi ();

    caf_match u_match (
        .f (fi.core)
    );

    // packs the four filter bytes, byte0 in the top
    function automatic logic [31:0] pack4(input logic [7:0] b0, input logic [7:0] b1,
                                          input logic [7:0] b2, input logic [7:0] b3);
        return {b0, b1, b2, b3};
    endfunction

    assign fi.code = pack4(code_r[0], code_r[1], code_r[2], code_r[3]);
    assign fi.mask = pack4(mask_r[0], mask_r[1], mask_r[2], mask_r[3]);
    assign fi.ext  = rx_ext;

    always_comb begin
        if (rx_ext) begin
            fi.frame = {rx_id, rx_rtr, 2'b00};
        end else begin
            // low three id bits then rtr
            fi.frame = {rx_id[10:3], rx_id[2:0], rx_rtr, 4'h0, rx_data0, rx_data1};
        end
    end

    assign hit = fi.match;

    // ---------------- apb slave ----------------
    // zero wait state: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;

    always_comb begin
        addr_ok = 1'b1;
        rd_nxt  = 32'h0000_0000;
        if (paddr == CAF_OFF_CODE0) begin
            rd_nxt = {24'h00_0000, code_r[0]};
        end else if (paddr == CAF_OFF_CODE1) begin
            rd_nxt = {24'h00_0000, code_r[1]};
        end else if (paddr == CAF_OFF_CODE2) begin
            rd_nxt = {24'h00_0000, code_r[2]};
        end else if (paddr == CAF_OFF_CODE3) begin
            rd_nxt = {24'h00_0000, code_r[3]};
        end else if (paddr == CAF_OFF_MASK0) begin
            rd_nxt = {24'h00_0000, mask_r[0]};
        end else if (paddr == CAF_OFF_MASK1) begin
            rd_nxt = {24'h00_0000, mask_r[1]};
        end else if (paddr == CAF_OFF_MASK2) begin
            rd_nxt = {24'h00_0000, mask_r[2]};
        end else if (paddr == CAF_OFF_MASK3) begin
            rd_nxt = {24'h00_0000, mask_r[3]};
        end else if (paddr == CAF_OFF_STATUS) begin
            rd_nxt = {29'h0000_0000, status_r};
        end else if (paddr == CAF_OFF_ACOUNT) begin
            rd_nxt = 32'(acount_r);
        end else if (paddr == CAF_OFF_RCOUNT) begin
            rd_nxt = 32'(rcount_r);
        end else begin
            addr_ok = 1'b0;
        end
    end

    // unmapped addresses answer with an error and read as zero
    assign pslverr = psel && penable && !addr_ok;
    // read data is combinational from registers so the zero-wait answer is valid
    assign prdata  = (rd_en && addr_ok) ? rd_nxt : 32'h0000_0000;

    // filter registers; writes only land through byte lane 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < CAF_NBYTES; i++) begin
                code_r[i] <= CAF_CODE_RST;
                mask_r[i] <= CAF_MASK_RST;
            end
        end else if (wr_en && pstrb[0]) begin
            if (paddr == CAF_OFF_CODE0) begin
                code_r[0] <= pwdata[7:0];
            end else if (paddr == CAF_OFF_CODE1) begin
                code_r[1] <= pwdata[7:0];
            end else if (paddr == CAF_OFF_CODE2) begin
                code_r[2] <= pwdata[7:0];
            end else if (paddr == CAF_OFF_CODE3) begin
                code_r[3] <= pwdata[7:0];
            end else if (paddr == CAF_OFF_MASK0) begin
                mask_r[0] <= pwdata[7:0];
            end else if (paddr == CAF_OFF_MASK1) begin
                mask_r[1] <= pwdata[7:0];
            end else if (paddr == CAF_OFF_MASK2) begin
                mask_r[2] <= pwdata[7:0];
            end else if (paddr == CAF_OFF_MASK3) begin
                mask_r[3] <= pwdata[7:0];
            end
        end
    end

    // ---------------- decision ----------------
    // pass or reject
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_valid <= 1'b0;
            acc_pass  <= 1'b0;
        end else begin
            acc_valid <= rx_valid;
            acc_pass  <= rx_valid && hit;
        end
    end

    // last decision, readable by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= 3'b000;
        end else if (rx_valid) begin
            status_r[CAF_ST_VALID]  <= 1'b1;
            status_r[CAF_ST_ACCEPT] <= hit;
            status_r[CAF_ST_EXT]    <= rx_ext;
        end
    end

    // counters wrap; a write to a counter clears it, a frame in that cycle still counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acount_r <= '0;
            rcount_r <= '0;
        end else begin
            if (rx_valid && hit) begin
                acount_r <= (wr_en && paddr == CAF_OFF_ACOUNT) ? CNT_W'(1) : acount_r + 1'b1;
            end else if (wr_en && paddr == CAF_OFF_ACOUNT) begin
                acount_r <= '0;
            end
            if (rx_valid && !hit) begin
                rcount_r <= (wr_en && paddr == CAF_OFF_RCOUNT) ? CNT_W'(1) : rcount_r + 1'b1;
            end else if (wr_en && paddr == CAF_OFF_RCOUNT) begin
                rcount_r <= '0;
            end
        end
    end

    // ---------------- assertions ----------------
    // mask all ones: every frame passes, standard or extended
    all_mask_pass_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_valid && fi.mask == 32'hFFFF_FFFF) |=> acc_pass)
        else $error("open mask did not pass frame");

    // decision follows the frame strobe by one cycle
    decision_timing_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_valid |=> acc_valid)
        else $error("decision strobe missing");

    pass_needs_valid_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_pass |-> acc_valid)
        else $error("pass without decision strobe");

    // mismatch in id bit 10 rejects when compared
    std_top_bit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_valid && !rx_ext && !mask_r[0][7] && (rx_id[10] != code_r[0][7]))
        |=> !acc_pass)
        else $error("standard id bit ten mismatch passed");

    std_rtr_bit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_valid && !rx_ext && !mask_r[1][4] && (rx_rtr != code_r[1][4]))
        |=> !acc_pass)
        else $error("standard rtr mismatch passed");

    // mismatches confined to the byte1 low nibble never reject a standard frame
    std_low_nibble_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_valid && !rx_ext && ((fi.frame ^ fi.code) & ~fi.mask & 32'hFFF0_FFFF) == 32'h0000_0000)
        |=> acc_pass)
        else $error("standard low nibble affected decision");

    std_data0_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_valid && !rx_ext && mask_r[2] == 8'h00 && rx_data0 != code_r[2])
        |=> !acc_pass)
        else $error("data byte mismatch passed");

    // byte3 low two bits never matter for extended frames
    ext_low_bits_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_valid && rx_ext && ((fi.frame ^ fi.code) & ~fi.mask & 32'hFFFF_FFFC) == 32'h0000_0000)
        |=> acc_pass)
        else $error("extended low bits affected decision");

    // extended rtr sits at byte3 bit2
    ext_rtr_pos_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_valid && rx_ext && !mask_r[3][2] && (rx_rtr != code_r[3][2]))
        |=> !acc_pass)
        else $error("extended rtr mismatch passed");

    // a frame equal in every compared bit passes
    exact_match_pass_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_valid && ((fi.frame ^ fi.code) & ~fi.mask) == 32'h0000_0000) |=> acc_pass)
        else $error("exact match rejected");

    std_data1_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_valid && !rx_ext && mask_r[3] == 8'h00 && rx_data1 != code_r[3])
        |=> !acc_pass)
        else $error("second data byte mismatch passed");

    // extended id bit 28 sits at byte0 bit7
    ext_top_bit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_valid && rx_ext && !mask_r[0][7] && (rx_id[28] != code_r[0][7]))
        |=> !acc_pass)
        else $error("extended id bit mismatch passed");

    // every accepted frame steps the accept count unless that count is written in the same cycle
    accept_count_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_valid && hit && !(wr_en && paddr == CAF_OFF_ACOUNT))
        |=> acount_r == CNT_W'($past(acount_r) + 1'b1))
        else $error("accept count did not step");

    // every rejected frame steps the reject count unless that count is written in the same cycle
    reject_count_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_valid && !hit && !(wr_en && paddr == CAF_OFF_RCOUNT))
        |=> rcount_r == CNT_W'($past(rcount_r) + 1'b1))
        else $error("reject count did not step");

    // read data stays zero outside a read access
    idle_read_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !rd_en |-> prdata == 32'h0000_0000)
        else $error("read data outside read access");
endmodule

// ### tb/caf_node.sv
// behavioural can node that hands received frames to the filter
`timescale 1ns/1ps
module caf_node (
    input  wire logic        pclk,      // controller clock
    output logic             rx_valid,  // frame strobe
    output logic             rx_ext,    // extended frame
    output logic [28:0]      rx_id,     // identifier
    output logic             rx_rtr,    // remote request
    output logic [7:0]       rx_data0,  // first data byte
    output logic [7:0]       rx_data1   // second data byte
);
    initial begin
        rx_valid = 1'b0;
        {rx_ext, rx_id, rx_rtr, rx_data0, rx_data1} = '0;
    end
    // gap gives slow senders; fields are scrambled after the strobe so stale values never match
    task automatic send(input logic e, input logic [28:0] i, input logic r,
                        input logic [7:0] a, input logic [7:0] b, input int gap);
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        rx_valid <= 1'b1;
        {rx_ext, rx_id, rx_rtr, rx_data0, rx_data1} <= {e, i, r, a, b};
        @(posedge pclk);
        rx_valid <= 1'b0;
        {rx_ext, rx_id, rx_rtr, rx_data0, rx_data1} <= ~{e, i, r, a, b};
    endtask
endmodule

// ### tb/caf_top_tb.sv
// self-checking bench for the can acceptance filter
`timescale 1ns/1ps
module caf_top_tb;
    import caf_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        rx_valid, rx_ext, rx_rtr, acc_valid, acc_pass, e, r, ex;
    logic [7:0]  paddr, rx_data0, rx_data1, d0, d1;
    logic [3:0]  pstrb;
    logic [28:0] rx_id, id;
    logic [31:0] pwdata, prdata, rd, code, mask, fv, flip;
    int          err_total, num_checks, seed, n_acc, n_rej;

    caf_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
                 .prdata, .pready, .pslverr, .rx_valid, .rx_ext, .rx_id, .rx_rtr,
                 .rx_data0, .rx_data1, .acc_valid, .acc_pass);
    caf_node node (.pclk, .rx_valid, .rx_ext, .rx_id, .rx_rtr, .rx_data0, .rx_data1);

    always #50 pclk = ~pclk;

    function automatic logic [31:0] fvec(logic x, logic [28:0] i, logic t,
                                         logic [7:0] a, logic [7:0] b);
        return x ? {i, t, 2'b00} : {i[10:0], t, 4'h0, a, b};
    endfunction
    function automatic logic exp_pass(logic x, logic [31:0] c, logic [31:0] m,
                                      logic [31:0] f);
        logic [31:0] use_bits;
        use_bits = x ? {24'hFFFFFF, CAF_EXT_B3_USE} : {8'hFF, CAF_STD_B1_USE, 16'hFFFF};
        return ((f ^ c) & ~m & use_bits) == 32'h0;
    endfunction
    // fixed corners: exact, ignored bits, then one compared bit each for std rtr, data0, ext rtr, ext id bit 28 and data1
    function automatic logic [31:0] corner_flip(int t);
        case (t)
            1:       return 32'h0001_0000;
            2:       return 32'h0000_0001;
            3:       return 32'h0010_0000;
            4:       return 32'h0000_0100;
            5:       return 32'h0000_0004;
            6:       return 32'h8000_0000;
            7:       return 32'h0000_0001;
            default: return 32'h0000_0000;
        endcase
    endfunction

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exv, input logic [31:0] got);
        num_checks++;
        if (got !== exv) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exv, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            err_total++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        seed = 32'h6F1705CC;
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {err_total, num_checks, n_acc, n_rej} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0, 4'h0);
            chk("reset value", (i < 4) ? 32'h0 : 32'hFF, rd);
        end
        apb(1'b0, 8'h30, 32'h0, 4'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, CAF_OFF_CODE0, 32'h5A, 4'hE);
        apb(1'b0, CAF_OFF_CODE0, 32'h0, 4'h0);
        chk("strobe off write", 32'h0, rd);
        $display("register test done");
        // reset filter is wide open; this frame also gives the counter clear real work
        node.send(1'b0, 29'h5A5, 1'b1, 8'h3C, 8'hC3, 0);
        #1;
        chk("open mask", 32'h1, {31'h0, acc_pass});
        apb(1'b0, CAF_OFF_ACOUNT, 32'h0, 4'h0);
        chk("count before clear", 32'h1, rd);
        apb(1'b1, CAF_OFF_ACOUNT, 32'h0, 4'hF);
        apb(1'b1, CAF_OFF_RCOUNT, 32'h0, 4'hF);
        // frames below eight are the corners of corner_flip, with every bit compared
        for (int t = 0; t < 80; t++) begin
            e = 1'($random(seed));
            if (t < 8) e = (t == 2 || t == 5 || t == 6);
            id = 29'($random(seed));
            if (!e) id[28:11] = '0;
            r = 1'($random(seed));
            d0 = 8'($random(seed));
            d1 = 8'($random(seed));
            fv = fvec(e, id, r, d0, d1);
            mask = (t < 8) ? 32'h0 : 32'($random(seed));
            flip = 32'h1 << ($unsigned($random(seed)) % 32);
            if (t < 8) flip = corner_flip(t);
            else if ($random(seed) & 1) flip = 32'h0;
            code = fv ^ flip;
            for (int i = 0; i < 4; i++) begin
                apb(1'b1, 8'(i * 4), {24'h0, code[31 - 8 * i -: 8]}, 4'hF);
                apb(1'b1, 8'(16 + i * 4), {24'h0, mask[31 - 8 * i -: 8]}, 4'hF);
            end
            ex = exp_pass(e, code, mask, fv);
            if (ex) n_acc++;
            else n_rej++;
            node.send(e, id, r, d0, d1, t % 3);
            #1;
            chk("decision strobe", 32'h1, {31'h0, acc_valid});
            chk("accept", {31'h0, ex}, {31'h0, acc_pass});
            @(posedge pclk);
            #1;
            chk("strobe length", 32'h0, {31'h0, acc_valid});
        end
        $display("frame test done");
        apb(1'b0, CAF_OFF_ACOUNT, 32'h0, 4'h0);
        chk("accept count", 32'(n_acc), rd);
        apb(1'b0, CAF_OFF_RCOUNT, 32'h0, 4'h0);
        chk("reject count", 32'(n_rej), rd);
        apb(1'b0, CAF_OFF_STATUS, 32'h0, 4'h0);
        chk("status", {29'h0, e, ex, 1'b1}, rd);
        apb(1'b0, CAF_OFF_MASK0, 32'h0, 4'h0);
        chk("mask readback", {24'h0, mask[31:24]}, rd);
        $display("counter test done");
        give_verdict();
    end
endmodule
